// *** design/tps_sequencer.sv ***
// two-motor stepper sequencer with its register port
// Contract
// - three held drive signals per coil
// - two level bits pick four currents
// - off, hold when still, full when turning (code drives the mid code instead while turning with reduced set)
// - step by state change, interval sets speed
// - document motor cycles eight half-step states
// - reverse by walking the table backwards
// - carriage skips zero-current states
// - dir 1 forward, levels 00 full 11 off
// - fixed eight-entry winding sequence
// - separate ports per motor, timer driven steps
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "tps_consts.svh"

module tps_sequencer (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic doc_winding_a_dir_out,
    output logic doc_winding_a_level_bit_lo_out,
    output logic doc_winding_a_level_bit_hi_out,
    output logic doc_winding_b_dir_out,
    output logic doc_winding_b_level_bit_lo_out,
    output logic doc_winding_b_level_bit_hi_out,
    output logic car_winding_a_dir_out,
    output logic car_winding_a_level_bit_lo_out,
    output logic car_winding_a_level_bit_hi_out,
    output logic car_winding_b_dir_out,
    output logic car_winding_b_level_bit_lo_out,
    output logic car_winding_b_level_bit_hi_out
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [`TPS_CTRL_WIDTH-1:0] ctrl;
    logic [`TPS_LEVELS_WIDTH-1:0] levels;
    tps_pkg::tps_count_t period [2];
    tps_pkg::tps_drive_t drive [2];
    tps_pkg::tps_phase_t phase [2];
    tps_pkg::tps_count_t steps_left [2];
    logic [1:0] busy;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic hit_ctrl;
    wire logic hit_levels;
    wire logic hit_doc_period;
    wire logic hit_doc_steps;
    wire logic hit_car_period;
    wire logic hit_car_steps;
    wire logic hit_status;
    wire logic [1:0] wr_period;
    wire logic [1:0] wr_steps;
    wire tps_pkg::tps_level_t hold_code;
    wire tps_pkg::tps_level_t mid_code;
    wire logic [7:0] status_word;
    wire logic [1:0] motor_enable;
    wire logic [1:0] motor_forward;
    wire logic [1:0] motor_reduced;

    assign hit_ctrl = (reg_addr_in == `TPS_ADDR_CTRL);
    assign hit_levels = (reg_addr_in == `TPS_ADDR_LEVELS);
    assign hit_doc_period = (reg_addr_in == `TPS_ADDR_DOC_PERIOD);
    assign hit_doc_steps = (reg_addr_in == `TPS_ADDR_DOC_STEPS);
    assign hit_car_period = (reg_addr_in == `TPS_ADDR_CAR_PERIOD);
    assign hit_car_steps = (reg_addr_in == `TPS_ADDR_CAR_STEPS);
    assign hit_status = (reg_addr_in == `TPS_ADDR_STATUS);

    assign wr_period = {reg_wr_in && hit_car_period, reg_wr_in && hit_doc_period};
    assign wr_steps = {reg_wr_in && hit_car_steps, reg_wr_in && hit_doc_steps};

    // intermediate level codes are software's to set
    assign hold_code = levels[`TPS_LEVELS_HOLD_LSB +: 2];
    assign mid_code = levels[`TPS_LEVELS_MID_LSB +: 2];

    assign status_word = {busy[1], phase[1], busy[0], phase[0]};

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ctrl <= `TPS_CTRL_RESET;
            levels <= `TPS_LEVELS_RESET;
        end else begin
            if (reg_wr_in && hit_ctrl) begin
                ctrl <= reg_wdata_in[`TPS_CTRL_WIDTH-1:0];
            end
            if (reg_wr_in && hit_levels) begin
                levels <= reg_wdata_in[`TPS_LEVELS_WIDTH-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read path: unmapped addresses read zero
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_ctrl) begin
            next_rdata[`TPS_CTRL_WIDTH-1:0] = ctrl;
        end
        if (hit_levels) begin
            next_rdata[`TPS_LEVELS_WIDTH-1:0] = levels;
        end
        if (hit_doc_period) begin
            next_rdata[15:0] = period[0];
        end
        if (hit_doc_steps) begin
            next_rdata[15:0] = steps_left[0];
        end
        if (hit_car_period) begin
            next_rdata[15:0] = period[1];
        end
        if (hit_car_steps) begin
            next_rdata[15:0] = steps_left[1];
        end
        if (hit_status) begin
            next_rdata[7:0] = status_word;
        end
    end

    // data only in the cycle after the read strobe
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else begin
            reg_rdata_out <= reg_rd_in ? next_rdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // motor channels: 0 document feed, 1 carriage
    // ------------------------------------------------------------
    for (genvar m = 0; m < 2; m++) begin : g_motor
        assign motor_enable[m] = ctrl[m*`TPS_CTRL_BITS_PER_MOTOR + `TPS_CTRL_ENABLE];
        assign motor_reduced[m] = ctrl[m*`TPS_CTRL_BITS_PER_MOTOR + `TPS_CTRL_REDUCED];
        assign motor_forward[m] = ctrl[m*`TPS_CTRL_BITS_PER_MOTOR + `TPS_CTRL_FORWARD];

        always_ff @(posedge clk_sys_in) begin
            if (sys_rst_in) begin
                period[m] <= `TPS_COUNT_ZERO;
            end else if (wr_period[m]) begin
                period[m] <= reg_wdata_in[15:0];
            end
        end

        // document motor uses all eight states
        // carriage motor advances two states a step
        tps_motor_channel #(
            .FULL_ONLY(m == 1)
        ) u_channel (
            .clk_sys_in(clk_sys_in),
            .sys_rst_in(sys_rst_in),
            .enable_in(motor_enable[m]),
            .forward_in(motor_forward[m]),
            .reduced_in(motor_reduced[m]),
            .period_in(period[m]),
            .load_in(wr_steps[m]),
            .load_value_in(reg_wdata_in[15:0]),
            .hold_code_in(hold_code),
            .mid_code_in(mid_code),
            .drive_out(drive[m]),
            .phase_out(phase[m]),
            .busy_out(busy[m]),
            .steps_left_out(steps_left[m])
        );
    end

    // ------------------------------------------------------------
    // coil pins, straight from channel drive flops
    // ------------------------------------------------------------
    // document motor on its own port
    assign doc_winding_a_dir_out = drive[0][5];
    assign doc_winding_a_level_bit_hi_out = drive[0][4];
    assign doc_winding_a_level_bit_lo_out = drive[0][3];
    assign doc_winding_b_dir_out = drive[0][2];
    assign doc_winding_b_level_bit_hi_out = drive[0][1];
    assign doc_winding_b_level_bit_lo_out = drive[0][0];
    // carriage motor on a second port
    assign car_winding_a_dir_out = drive[1][5];
    assign car_winding_a_level_bit_hi_out = drive[1][4];
    assign car_winding_a_level_bit_lo_out = drive[1][3];
    assign car_winding_b_dir_out = drive[1][2];
    assign car_winding_b_level_bit_hi_out = drive[1][1];
    assign car_winding_b_level_bit_lo_out = drive[1][0];

endmodule : tps_sequencer
`default_nettype wire

// *** design/tps_consts.svh ***
// constants for the two-phase stepper sequencer
`ifndef TPS_CONSTS_SVH
`define TPS_CONSTS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define TPS_ADDR_CTRL 8'h00
`define TPS_ADDR_LEVELS 8'h04
`define TPS_ADDR_DOC_PERIOD 8'h08
`define TPS_ADDR_DOC_STEPS 8'h0c
`define TPS_ADDR_CAR_PERIOD 8'h10
`define TPS_ADDR_CAR_STEPS 8'h14
`define TPS_ADDR_STATUS 8'h18

// ------------------------------------------------------------
// control fields, per motor m: base bit 3*m
// ------------------------------------------------------------
`define TPS_CTRL_WIDTH 6
`define TPS_CTRL_BITS_PER_MOTOR 3
`define TPS_CTRL_ENABLE 0
`define TPS_CTRL_FORWARD 1
`define TPS_CTRL_REDUCED 2
`define TPS_CTRL_RESET 6'h00

// ------------------------------------------------------------
// level map fields and reset values
// ------------------------------------------------------------
`define TPS_LEVELS_WIDTH 4
`define TPS_LEVELS_HOLD_LSB 0
`define TPS_LEVELS_MID_LSB 2
`define TPS_LEVELS_RESET 4'h6
`define TPS_LEVEL_FULL 2'h0
`define TPS_LEVEL_OFF 2'h3

// ------------------------------------------------------------
// status fields, per motor m: base bit 4*m
// ------------------------------------------------------------
`define TPS_STATUS_BITS_PER_MOTOR 4
`define TPS_STATUS_BUSY 3

// ------------------------------------------------------------
// sequence: {a_dir, a_hi, a_lo, b_dir, b_hi, b_lo}
// ------------------------------------------------------------
`define TPS_SEQ_0 6'h24
`define TPS_SEQ_1 6'h23
`define TPS_SEQ_2 6'h20
`define TPS_SEQ_3 6'h18
`define TPS_SEQ_4 6'h00
`define TPS_SEQ_5 6'h07
`define TPS_SEQ_6 6'h04
`define TPS_SEQ_7 6'h3c
`define TPS_HALF_ADVANCE 3'h1
`define TPS_FULL_ADVANCE 3'h2
`define TPS_PHASE_RESET 3'h0
`define TPS_COUNT_ZERO 16'h0000
`define TPS_COUNT_STEP 16'h0001
`define TPS_DRIVE_RESET 6'h3f

`endif

// *** design/tps_pkg.sv ***
// shared types of the two-phase stepper sequencer
package tps_pkg;
    typedef logic [2:0] tps_phase_t;
    typedef logic [15:0] tps_count_t;
    typedef logic [5:0] tps_drive_t;
    typedef logic [1:0] tps_level_t;
endpackage : tps_pkg

// *** design/tps_motor_channel.sv ***
// one motor: phase index, step timer, step budget and coil drive
`timescale 1ns/10ps
`default_nettype none
`include "tps_consts.svh"

module tps_motor_channel #(
    parameter bit FULL_ONLY = 1'b0
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic enable_in,
    input wire logic forward_in,
    input wire logic reduced_in,
    input wire tps_pkg::tps_count_t period_in,
    input wire logic load_in,
    input wire tps_pkg::tps_count_t load_value_in,
    input wire tps_pkg::tps_level_t hold_code_in,
    input wire tps_pkg::tps_level_t mid_code_in,
    output tps_pkg::tps_drive_t drive_out,
    output tps_pkg::tps_phase_t phase_out,
    output logic busy_out,
    output tps_pkg::tps_count_t steps_left_out
);

    tps_pkg::tps_count_t tick_cnt;
    tps_pkg::tps_drive_t pattern;
    tps_pkg::tps_drive_t next_drive;
    tps_pkg::tps_phase_t next_phase;
    tps_pkg::tps_level_t run_code;
    tps_pkg::tps_level_t live_code;
    tps_pkg::tps_level_t a_code;
    tps_pkg::tps_level_t b_code;
    wire logic busy;
    wire logic step_due;
    wire tps_pkg::tps_phase_t advance;

    // ------------------------------------------------------------
    // stepping
    // ------------------------------------------------------------
    assign busy = (steps_left_out != `TPS_COUNT_ZERO) && enable_in;
    assign step_due = busy && (tick_cnt >= period_in);
    assign advance = FULL_ONLY ? `TPS_FULL_ADVANCE : `TPS_HALF_ADVANCE;
    assign next_phase = forward_in ? 3'(phase_out + advance) : 3'(phase_out - advance);

    always_comb begin
        unique case (phase_out)
            3'h0: pattern = `TPS_SEQ_0;
            3'h1: pattern = `TPS_SEQ_1;
            3'h2: pattern = `TPS_SEQ_2;
            3'h3: pattern = `TPS_SEQ_3;
            3'h4: pattern = `TPS_SEQ_4;
            3'h5: pattern = `TPS_SEQ_5;
            3'h6: pattern = `TPS_SEQ_6;
            3'h7: pattern = `TPS_SEQ_7;
        endcase
    end

    // ------------------------------------------------------------
    // level mapping
    // ------------------------------------------------------------
    // two bits pick one of four levels
    // full (mid code if reduced) while rotating, hold when stopped
    assign run_code = reduced_in ? mid_code_in : `TPS_LEVEL_FULL;
    // hold code applied once stepping stops
    assign live_code = busy ? run_code : hold_code_in;
    // off stays off, full maps to live level
    assign a_code = (pattern[4:3] == `TPS_LEVEL_OFF) ? `TPS_LEVEL_OFF : live_code;
    assign b_code = (pattern[1:0] == `TPS_LEVEL_OFF) ? `TPS_LEVEL_OFF : live_code;
    // disabled motor has both coils off
    assign next_drive = enable_in ? {pattern[5], a_code, pattern[2], b_code}
                                  : {pattern[5], `TPS_LEVEL_OFF, pattern[2], `TPS_LEVEL_OFF};

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            tick_cnt <= `TPS_COUNT_ZERO;
            phase_out <= `TPS_PHASE_RESET;
            steps_left_out <= `TPS_COUNT_ZERO;
        end else begin
            tick_cnt <= (step_due || !busy) ? `TPS_COUNT_ZERO : 16'(tick_cnt + `TPS_COUNT_STEP);
            if (step_due) begin
                phase_out <= next_phase;
            end
            // new budget overrides a step's decrement in the same cycle; the phase still advances
            if (load_in) begin
                steps_left_out <= load_value_in;
            end else if (step_due) begin
                steps_left_out <= 16'(steps_left_out - `TPS_COUNT_STEP);
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            drive_out <= `TPS_DRIVE_RESET;
            busy_out <= 1'b0;
        end else begin
            drive_out <= next_drive;
            busy_out <= busy;
        end
    end

endmodule : tps_motor_channel
`default_nettype wire

// *** testbench/tps_coil_model.sv ***
// coil driver model: signed current percentage seen by one winding
`timescale 1ns/10ps
`default_nettype none
module tps_coil_model (
    input wire logic dir_in,
    input wire logic hi_in,
    input wire logic lo_in,
    output int pct_out
);
    // three-signal current decode
    // middle codes follow the reset mapping: 10 hold, 01 mid
    always_comb begin
        case ({hi_in, lo_in})
            2'b00: pct_out = 100;
            2'b11: pct_out = 0;
            2'b10: pct_out = 20;
            default: pct_out = 60;
        endcase
        if (!dir_in) pct_out = -pct_out;
    end
endmodule : tps_coil_model
`default_nettype wire

// *** testbench/tps_sequencer_properties.sv ***
// port-level assertions for the stepper sequencer
`timescale 1ns/10ps
`default_nettype none
module tps_seq_checker (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic [2:0] da,
    input wire logic [2:0] db,
    input wire logic [2:0] ca,
    input wire logic [2:0] cb
);
    default clocking dc @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    a_read_idle_zero:
    assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0) else $error("read data outside read slot");
    a_unmapped_zero:
    assert property ($past(reg_rd_in) && $past(reg_addr_in) > 8'h18 |-> reg_rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero:
    assert property (reg_rdata_out[31:16] == 16'h0) else $error("upper read bits set");
    a_reset_coils_off:
    assert property ($past(sys_rst_in) |-> {da, db, ca, cb} == 12'hfff) else $error("coils live after reset");
    a_doc_b_off_dir:
    assert property (da[1:0] == 2'b00 && db[1:0] == 2'b11 |-> db[2] != da[2]) else $error("doc B off dir");
    a_doc_a_off_dir:
    assert property (db[1:0] == 2'b00 && da[1:0] == 2'b11 |-> db[2] == da[2]) else $error("doc A off dir");
    a_car_never_off:
    assert property ((ca[1:0] == 2'b11) == (cb[1:0] == 2'b11)) else $error("carriage single coil off");
    a_doc_half_step:
    assert property ({da[1:0], db[1:0]} == 4'h0 && $past({da[1:0], db[1:0]}) == 4'h0 |-> $stable({da[2], db[2]}))
        else $error("doc skipped a half step");
    a_car_one_coil:
    assert property ({ca[1:0], cb[1:0]} == 4'h0 |-> $countones({ca[2], cb[2]} ^ $past({ca[2], cb[2]})) <= 1)
        else $error("carriage swapped both coils");
endmodule : tps_seq_checker
bind tps_sequencer tps_seq_checker u_chk (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .da({doc_winding_a_dir_out, doc_winding_a_level_bit_hi_out, doc_winding_a_level_bit_lo_out}),
    .db({doc_winding_b_dir_out, doc_winding_b_level_bit_hi_out, doc_winding_b_level_bit_lo_out}),
    .ca({car_winding_a_dir_out, car_winding_a_level_bit_hi_out, car_winding_a_level_bit_lo_out}),
    .cb({car_winding_b_dir_out, car_winding_b_level_bit_hi_out, car_winding_b_level_bit_lo_out}));
`default_nettype wire

// *** testbench/tps_sequencer_tb.sv ***
// self-checking bench for the stepper sequencer
`timescale 1ns/10ps
`default_nettype none
module tps_sequencer_tb;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    wire logic [5:0] dp;
    wire logic [5:0] cp;
    int pct [4];
    int err_count = 0;
    int checks_done = 0;
    logic [5:0] seq [8] = '{6'h24, 6'h23, 6'h20, 6'h18, 6'h00, 6'h07, 6'h04, 6'h3c};
    logic [2:0] ph [2] = '{3'h0, 3'h0};

    // ----------------------------------------
    // design and coil models
    // ----------------------------------------
    tps_sequencer DUT (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .doc_winding_a_dir_out(dp[5]), .doc_winding_a_level_bit_hi_out(dp[4]), .doc_winding_a_level_bit_lo_out(dp[3]),
        .doc_winding_b_dir_out(dp[2]), .doc_winding_b_level_bit_hi_out(dp[1]), .doc_winding_b_level_bit_lo_out(dp[0]),
        .car_winding_a_dir_out(cp[5]), .car_winding_a_level_bit_hi_out(cp[4]), .car_winding_a_level_bit_lo_out(cp[3]),
        .car_winding_b_dir_out(cp[2]), .car_winding_b_level_bit_hi_out(cp[1]), .car_winding_b_level_bit_lo_out(cp[0]));
    for (genvar g = 0; g < 4; g++) begin : g_coil
        wire logic [2:0] c = (g < 2) ? dp[5 - 3 * (g % 2) -: 3] : cp[5 - 3 * (g % 2) -: 3];
        tps_coil_model u_coil (.dir_in(c[2]), .hi_in(c[1]), .lo_in(c[0]), .pct_out(pct[g]));
    end

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_reg
    function automatic logic [5:0] xf(input logic [5:0] s, input logic [1:0] c);
        xf = s;
        if (s[1:0] == 2'b00) xf[1:0] = c;
        if (s[4:3] == 2'b00) xf[4:3] = c;
    endfunction : xf
    // waits for the pins of one motor to differ from p, counting cycles
    task automatic wait_chg(input logic m, input logic [5:0] p, output int n);
        n = 0;
        do begin
            @(posedge clk_sys_in);
            #1 n++;
        end while ((m ? cp : dp) === p && n < 40);
    endtask : wait_chg

    // ----------------------------------------
    // one stepping run, then hold and disable
    // ----------------------------------------
    task automatic run(input logic m, input logic fwd, input logic red, input logic [15:0] per,
                       input logic [15:0] n, input logic [3:0] lv);
        int c;
        logic [5:0] e;
        logic [2:0] st;
        st = m ? 3'h2 : 3'h1;
        wr_reg(8'h04, {28'h0, lv});
        wr_reg(8'h08 + {4'h0, m, 3'h0}, {16'h0, per});
        wr_reg(8'h00, 32'({red, fwd, 1'b1}) << (3 * m));
        wr_reg(8'h0c + {4'h0, m, 3'h0}, {16'h0, n});
        e = xf(seq[ph[m]], red ? lv[3:2] : 2'b00);
        c = 0;
        while ((m ? cp : dp) !== e && c < 40) begin
            @(posedge clk_sys_in);
            #1 c++;
        end
        chk({26'h0, m ? cp : dp}, {26'h0, e});
        for (int k = 0; k < n; k++) begin
            wait_chg(m, e, c);
            ph[m] = fwd ? ph[m] + st : ph[m] - st;
            // the last step lands straight on the hold code
            e = xf(seq[ph[m]], (k == n - 1) ? lv[1:0] : (red ? lv[3:2] : 2'b00));
            chk({26'h0, m ? cp : dp}, {26'h0, e});
            if (k > 0) chk(c, per + 32'h1);
        end
        repeat (3) @(posedge clk_sys_in);
        #1 chk({26'h0, m ? cp : dp}, {26'h0, e});
        rd_reg(8'h18, {24'h0, 1'b0, ph[1], 1'b0, ph[0]});
        rd_reg(8'h0c + {4'h0, m, 3'h0}, 32'h0);
        wr_reg(8'h00, 32'h0);
        wait_chg(m, e, c);
        chk({26'h0, m ? cp : dp}, {26'h0, e[5], 2'b11, e[2], 2'b11});
        chk(pct[2 * m] + pct[2 * m + 1], 32'h0);
    endtask : run

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_values;
        chk({20'h0, dp, cp}, 32'hfff);
        rd_reg(8'h00, 32'h0);
        rd_reg(8'h04, 32'h6);
        rd_reg(8'h1c, 32'h0);
    endtask : t_reset_values
    task automatic t_doc_runs;
        run(1'b0, 1'b1, 1'b0, 16'h2, 16'h9, 4'h6);
        run(1'b0, 1'b0, 1'b0, 16'h3, 16'h3, 4'h9);
    endtask : t_doc_runs
    task automatic t_car_runs;
        run(1'b1, 1'b1, 1'b1, 16'h2, 16'h5, 4'h6);
        run(1'b1, 1'b0, 1'b0, 16'h4, 16'h3, 4'h6);
    endtask : t_car_runs
    // status is read-only, unmapped writes vanish
    task automatic t_refused;
        wr_reg(8'h18, 32'hff);
        wr_reg(8'h1c, 32'hff);
        rd_reg(8'h18, {24'h0, 1'b0, ph[1], 1'b0, ph[0]});
        rd_reg(8'h1c, 32'h0);
    endtask : t_refused

    task automatic complete_run;
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        err_count++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        #1 t_reset_values();
        t_doc_runs();
        t_car_runs();
        t_refused();
        complete_run();
    end
endmodule : tps_sequencer_tb
`default_nettype wire
